// ### event_sink_model.sv
// host-side taker of key events from the general-purpose line block
// assumes one clock and an active-low reset shared with the block
`timescale 1ns/1ps
`default_nettype none
module event_sink_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       stall_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] code_i,
  output logic            ready_o,
  output logic      [7:0] code_o,
  output logic      [7:0] count_o
);
  // ==========================================
  // event taking, stalls on request
  assign ready_o = !stall_i;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      code_o  <= 8'h00;
      count_o <= 8'h00;
    end else if (valid_i && ready_o) begin
      code_o  <= code_i;
      count_o <= count_o + 8'h01;
    end
  end
endmodule // event_sink_model
`default_nettype wire

// ### gpio_block_pkg.sv
// types for the keypad expander general-purpose line block
// assumes gpio_block_regs.svh is on the include path
package gpio_block_pkg;
  typedef enum logic [1:0] {
    INT_IDLE = 2'b00,
    INT_ON   = 2'b01,
    INT_GAP  = 2'b11
  } int_state_t;
endpackage

// ### gpio_block_regs.svh
// constants for the keypad expander general-purpose line block
// assumes inclusion by the design file only
`ifndef GPIO_BLOCK_REGS_SVH
`define GPIO_BLOCK_REGS_SVH
`define N_LINES        18
`define N_ROWS         8
`define ROW_CODE_BASE  7'h61
`define COL_CODE_BASE  7'h69
`define LAST_CODE      7'h72
`define DEB_TIME_NS    275000
`define CLK_PERIOD_NS  20
`define DEB_CYCLES     (`DEB_TIME_NS / `CLK_PERIOD_NS)
`define INT_GAP_CYCLES (`DEB_TIME_NS / `CLK_PERIOD_NS)
`define EVT_PRESS_BIT  7
`endif

// ### keypad_expander_gpio_block.sv
// general-purpose line block of a keypad and port expander
// assumes register writes arrive as pulses from the host-side register file
`include "gpio_block_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module keypad_expander_gpio_block
  import gpio_block_pkg::*;
#(
  parameter int N_LINES    = `N_LINES,
  parameter int DEB_CYCLES = `DEB_CYCLES,
  parameter int GAP_CYCLES = `INT_GAP_CYCLES
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_b_i,
  input  wire logic [N_LINES-1:0] pin_i,
  output logic      [N_LINES-1:0] pin_o,
  output logic      [N_LINES-1:0] pin_oe_o,
  output logic      [N_LINES-1:0] pull_up_en_o,
  input  wire logic [N_LINES-1:0] gpio_mode_i,
  input  wire logic [N_LINES-1:0] dir_out_i,
  input  wire logic [N_LINES-1:0] out_data_i,
  input  wire logic [N_LINES-1:0] pull_dis_i,
  input  wire logic [N_LINES-1:0] int_en_i,
  input  wire logic [N_LINES-1:0] int_level_i,
  input  wire logic [N_LINES-1:0] deb_dis_i,
  input  wire logic [N_LINES-1:0] input_event_mode_select_i,
  input  wire logic               locked_input_event_global_cfg_i,
  input  wire logic               keypad_locked_i,
  input  wire logic               int_pulse_cfg_i,
  input  wire logic               int_clear_i,
  input  wire logic               int_stat_rd_i,
  input  wire logic               event_pending_i,
  input  wire logic               event_ready_i,
  output logic      [N_LINES-1:0] data_stat_o,
  output logic      [N_LINES-1:0] int_stat_o,
  output logic                    event_valid_o,
  output logic      [7:0]         event_code_o,
  output logic                    int_b_o,
  output logic                    int_oe_o,
  output logic                    rst_done_o
);

  initial begin
    if (N_LINES != `N_LINES) $error("line count must be 18");
    if (DEB_CYCLES < 1 || GAP_CYCLES < 1) $error("counts must be >= 1");
    if (DEB_CYCLES > 65536) $error("debounce count exceeds 16 bits");
  end

  // ==========================================================
  // reset synchroniser and debounce
  logic        rs1_q, rs2_q;
  logic [31:0] rst_cnt_q   = 32'h0000_0000;
  logic        deb_rst_n_q = 1'b0;
  logic        rst_n;

  // pin synchroniser: a short low pulse must not reset anything
  always_ff @(posedge ref_clk_i) begin
    rs1_q <= rst_b_i;
    rs2_q <= rs1_q;
  end

  // pin low must persist for the debounce time before acting
  always_ff @(posedge ref_clk_i) begin
    if (rs2_q) begin
      rst_cnt_q   <= 32'h0000_0000;
      deb_rst_n_q <= 1'b1;
    end else if (rst_cnt_q >= 32'(DEB_CYCLES - 1)) begin
      deb_rst_n_q <= 1'b0;
    end else begin
      rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
    end
  end
  assign rst_n      = deb_rst_n_q;
  assign rst_done_o = deb_rst_n_q;

  // ==========================================================
  // pin synchronisers and per-line debounce
  logic [N_LINES-1:0] p1_q, p2_q, deb_q;
  logic [15:0]        dcnt_q [N_LINES];
  logic [N_LINES-1:0] is_in;
  assign is_in = gpio_mode_i & ~dir_out_i;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      p1_q <= '0;
      p2_q <= '0;
    end else begin
      p1_q <= pin_i;
      p2_q <= p1_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      deb_q <= '0;
      for (int i = 0; i < N_LINES; i++) dcnt_q[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < N_LINES; i++) begin
        if (p2_q[i] == deb_q[i]) begin
          dcnt_q[i] <= 16'h0000;
        end else if (deb_dis_i[i] ||
                     dcnt_q[i] >= 16'(DEB_CYCLES - 1)) begin
          deb_q[i]  <= p2_q[i];
          dcnt_q[i] <= 16'h0000;
        end else begin
          dcnt_q[i] <= dcnt_q[i] + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // outputs and pulls
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_o        <= '0;
      pin_oe_o     <= '0;
      pull_up_en_o <= '0;
    end else begin
      pin_o        <= out_data_i;
      pin_oe_o     <= gpio_mode_i & dir_out_i;
      pull_up_en_o <= is_in & ~pull_dis_i;
    end
  end

  // ==========================================================
  // status: data and sticky interrupt, clear on read
  logic [N_LINES-1:0] active;
  assign active = is_in & ~(deb_q ^ int_level_i);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_stat_o <= '0;
      int_stat_o  <= '0;
    end else begin
      data_stat_o <= deb_q & is_in;
      // set wins over clear on read
      int_stat_o  <= (int_stat_rd_i ? '0 : int_stat_o) |
                     (active & int_en_i);
    end
  end

  // ==========================================================
  // event logging: press on active, then watch opposite
  logic [N_LINES-1:0] armed_q, pend_q;
  logic [N_LINES-1:0] pend_press_q;
  logic               blocked;
  logic [N_LINES-1:0] logging;
  int                 sel;
  logic [4:0]         cur_q;

  // blocked while locked when either opt-out applies
  assign blocked = keypad_locked_i & locked_input_event_global_cfg_i;
  assign logging = input_event_mode_select_i & is_in &
                   ~({N_LINES{blocked}} |
                     ({N_LINES{keypad_locked_i}} &
                      input_event_mode_select_i));

  always_comb begin
    sel = -1;
    for (int i = N_LINES - 1; i >= 0; i--) begin
      if (pend_q[i]) sel = i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      armed_q      <= '0;
      pend_q       <= '0;
      pend_press_q <= '0;
    end else begin
      for (int i = 0; i < N_LINES; i++) begin
        if (event_valid_o && event_ready_i && cur_q == 5'(i)) begin
          pend_q[i] <= 1'b0;
        end
        if (logging[i] && !pend_q[i]) begin
          if (active[i] && !armed_q[i]) begin
            armed_q[i]      <= 1'b1;
            pend_q[i]       <= 1'b1;
            pend_press_q[i] <= 1'b1;
          end else if (!active[i] && armed_q[i]) begin
            armed_q[i]      <= 1'b0;
            pend_q[i]       <= 1'b1;
            pend_press_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  // code: rows from 97, columns from 105
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      event_valid_o <= 1'b0;
      event_code_o  <= 8'h00;
      cur_q         <= 5'h00;
    end else if (!event_valid_o || event_ready_i) begin
      event_valid_o <= 1'b0;
      if (sel >= 0 && !(event_valid_o && event_ready_i)) begin
        event_valid_o <= 1'b1;
        cur_q         <= 5'(sel);
        event_code_o[`EVT_PRESS_BIT] <= pend_press_q[sel];
        event_code_o[6:0] <= (sel < `N_ROWS) ?
          7'(`ROW_CODE_BASE + sel) :
          7'(`COL_CODE_BASE + sel - `N_ROWS);
      end
    end
  end

  // ==========================================================
  // interrupt output with optional gap
  int_state_t  ist_q;
  logic [31:0] gap_q;
  logic        cause;
  assign cause = |(int_stat_o & int_en_i) | event_pending_i;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ist_q <= INT_IDLE;
      gap_q <= 32'h0000_0000;
    end else begin
      case (ist_q)
        INT_IDLE: if (cause) ist_q <= INT_ON;
        INT_ON: begin
          if (!cause) ist_q <= INT_IDLE;
          else if (int_clear_i && int_pulse_cfg_i) begin
            ist_q <= INT_GAP;
            gap_q <= 32'h0000_0000;
          end
        end
        INT_GAP: begin
          if (gap_q >= 32'(GAP_CYCLES - 1)) ist_q <= INT_IDLE;
          else gap_q <= gap_q + 32'h0000_0001;
        end
        default: ist_q <= INT_IDLE;
      endcase
    end
  end
  assign int_b_o  = 1'b0;
  assign int_oe_o = (ist_q == INT_ON);

  // ==========================================================
  // checks
  property p_out_drive;
    @(posedge ref_clk_i) disable iff (!rst_n)
      1 |=> pin_oe_o == $past(gpio_mode_i & dir_out_i);
  endproperty
  a_out_drive: assert property (p_out_drive)
    else $error("output enable wrong");

  property p_gap_hold;
    @(posedge ref_clk_i) disable iff (!rst_n)
      (ist_q == INT_ON && int_clear_i && int_pulse_cfg_i && cause)
      |=> !int_oe_o;
  endproperty
  a_gap_hold: assert property (p_gap_hold)
    else $error("no gap after clear");

  property p_no_gap;
    @(posedge ref_clk_i) disable iff (!rst_n)
      (int_oe_o && !int_pulse_cfg_i && event_pending_i) |=> int_oe_o;
  endproperty
  a_no_gap: assert property (p_no_gap)
    else $error("interrupt dropped");

  property p_int_cause;
    @(posedge ref_clk_i) disable iff (!rst_n)
      (ist_q == INT_IDLE && cause) |=> int_oe_o;
  endproperty
  a_int_cause: assert property (p_int_cause)
    else $error("interrupt not raised");

  property p_rd_clear;
    @(posedge ref_clk_i) disable iff (!rst_n)
      (int_stat_rd_i && !(|(active & int_en_i))) |=> int_stat_o == '0;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("status not cleared");

  property p_code_range;
    @(posedge ref_clk_i) disable iff (!rst_n)
      event_valid_o |-> event_code_o[6:0] >= `ROW_CODE_BASE &&
                        event_code_o[6:0] <= `LAST_CODE;
  endproperty
  a_code_range: assert property (p_code_range)
    else $error("event code out of range");

  property p_locked;
    @(posedge ref_clk_i) disable iff (!rst_n)
      (keypad_locked_i && locked_input_event_global_cfg_i) |=>
        $stable(armed_q) || !keypad_locked_i;
  endproperty
  a_locked: assert property (p_locked)
    else $error("event logged while locked");

  property p_data_stat;
    @(posedge ref_clk_i) disable iff (!rst_n)
      1 |=> data_stat_o == $past(deb_q & is_in);
  endproperty
  a_data_stat: assert property (p_data_stat)
    else $error("data status wrong");

endmodule // keypad_expander_gpio_block
`default_nettype wire

// ### tb_keypad_expander_gpio_block.sv
// self-checking bench for the general-purpose line block
// assumes the block, its package and event_sink_model compile first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
    end \
  end
module tb_keypad_expander_gpio_block;
  localparam int N   = 18;
  localparam int DEB = 4;
  logic         ref_clk_i, rst_b_i, stall, lock, gcfg, pcfg, clr, rd, pend;
  logic [N-1:0] ext, mode, dir, dout, pdis, ien, lvl, em;
  wire  [N-1:0] pin, po, oe, pu, dst, ist;
  wire  [7:0]   code, scode, scnt;
  wire          vld, rdy, intb, ioe, done;
  int           fails, checked;
  // ==========================================
  // clock, wire level, block and partner
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  assign pin = (oe & po) | (~oe & ext);
  keypad_expander_gpio_block #(.DEB_CYCLES(DEB), .GAP_CYCLES(DEB)) uut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .pin_i(pin), .pin_o(po),
    .pin_oe_o(oe), .pull_up_en_o(pu), .gpio_mode_i(mode),
    .dir_out_i(dir), .out_data_i(dout), .pull_dis_i(pdis),
    .int_en_i(ien), .int_level_i(lvl), .deb_dis_i(18'h00000),
    .input_event_mode_select_i(em),
    .locked_input_event_global_cfg_i(gcfg), .keypad_locked_i(lock),
    .int_pulse_cfg_i(pcfg), .int_clear_i(clr), .int_stat_rd_i(rd),
    .event_pending_i(pend), .event_ready_i(rdy), .data_stat_o(dst),
    .int_stat_o(ist), .event_valid_o(vld), .event_code_o(code),
    .int_b_o(intb), .int_oe_o(ioe), .rst_done_o(done));
  event_sink_model sink (.clk_i(ref_clk_i), .rst_b_i(done),
    .stall_i(stall), .valid_i(vld), .code_i(code), .ready_o(rdy),
    .code_o(scode), .count_o(scnt));
  // ==========================================
  // shared tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wait_on(input bit sel, input logic v);
    int k = 0;
    while ((sel ? done : vld) !== v && k < 60) begin
      cyc(1);
      k++;
    end
    if (k == 60) begin
      fails++;
      $display("unexpected wait: expected %0h seen %0h", v, ~v);
      tally_and_finish();
    end
    if (sel) cyc(4);
  endtask
  // ==========================================
  // scenarios
  task automatic t_out();
    @(posedge ref_clk_i) mode <= '1;
    @(posedge ref_clk_i);
    dir  <= 18'h2A5A5;
    dout <= 18'h3C3C3;
    pdis <= 18'h00FF0;
    cyc(4);
    `CHK("drive enable", 18'h2A5A5, oe)
    `CHK("drive level", 18'h28181, po & dir)
    `CHK("pull-ups", 18'h1500A, pu)
    @(posedge ref_clk_i) dout <= 18'h03C3C;
    cyc(3);
    `CHK("drive level", 18'h02424, po & dir)
    $display("test out done");
  endtask
  task automatic t_rst();
    @(posedge ref_clk_i) rst_b_i <= 1'b0;
    @(posedge ref_clk_i) rst_b_i <= 1'b1;
    cyc(DEB + 6);
    `CHK("glitch done", 1'b1, done)
    `CHK("glitch enable", 18'h2A5A5, oe)
    @(posedge ref_clk_i) rst_b_i <= 1'b0;
    cyc(DEB + 8);
    `CHK("reset done", 1'b0, done)
    `CHK("reset enable", 18'h00000, oe)
    `CHK("reset int", 1'b0, ioe)
    @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    dir     <= '0;
    wait_on(1, 1'b1);
    `CHK("pull-ups", 18'h3F00F, pu)
    `CHK("status", 18'h00000, ist)
    $display("test rst done");
  endtask
  task automatic t_events();
    logic [6:0] c;
    @(posedge ref_clk_i);
    lvl <= 18'h2AAAA;
    ext <= 18'h15555;
    cyc(DEB + 6);
    @(posedge ref_clk_i) em <= '1;
    for (int i = 0; i < N; i++) begin
      c = (i < 8) ? 7'h61 + 7'(i) : 7'h69 + 7'(i - 8);
      @(posedge ref_clk_i);
      ext[i] <= lvl[i];
      stall  <= 1'b1;
      wait_on(0, 1'b1);
      `CHK("press code", {1'b1, c}, code)
      cyc(3);
      `CHK("held valid", 1'b1, vld)
      `CHK("held code", {1'b1, c}, code)
      @(posedge ref_clk_i) stall <= 1'b0;
      wait_on(0, 1'b0);
      `CHK("taken code", {1'b1, c}, scode)
      @(posedge ref_clk_i) ext[i] <= ~lvl[i];
      wait_on(0, 1'b1);
      `CHK("release code", {1'b0, c}, code)
      wait_on(0, 1'b0);
    end
    `CHK("event count", 8'h24, scnt)
    $display("test events done");
  endtask
  task automatic t_lock();
    @(posedge ref_clk_i) lock <= 1'b1;
    gcfg <= 1'b1;
    @(posedge ref_clk_i) ext[0] <= 1'b0;
    cyc(DEB + 8);
    `CHK("locked event", 1'b0, vld)
    @(posedge ref_clk_i) ext[0] <= 1'b1;
    cyc(DEB + 8);
    `CHK("locked release", 1'b0, vld)
    @(posedge ref_clk_i) lock <= 1'b0;
    gcfg <= 1'b0;
    @(posedge ref_clk_i) ext[0] <= 1'b0;
    wait_on(0, 1'b1);
    `CHK("unlocked code", 8'hE1, code)
    wait_on(0, 1'b0);
    @(posedge ref_clk_i) ext[0] <= 1'b1;
    wait_on(0, 1'b1);
    `CHK("unlocked code", 8'h61, code)
    wait_on(0, 1'b0);
    $display("test lock done");
  endtask
  task automatic t_int();
    @(posedge ref_clk_i) em <= '0;
    @(posedge ref_clk_i) ien <= 18'h00003;
    @(posedge ref_clk_i) ext[1] <= 1'b1;
    cyc(2);
    ext[1] <= 1'b0;
    cyc(DEB + 6);
    `CHK("glitch data", 18'h00000, dst & 18'h00002)
    `CHK("glitch status", 18'h00000, ist)
    @(posedge ref_clk_i);
    ext[0] <= 1'b0;
    ext[1] <= 1'b1;
    cyc(DEB + 6);
    `CHK("data status", 18'h00002, dst & 18'h00003)
    `CHK("int status", 18'h00003, ist)
    `CHK("int out", 1'b1, ioe)
    `CHK("int level", 1'b0, intb)
    @(posedge ref_clk_i);
    ext[0] <= 1'b1;
    ext[1] <= 1'b0;
    cyc(DEB + 6);
    @(posedge ref_clk_i) rd <= 1'b1;
    @(posedge ref_clk_i) rd <= 1'b0;
    cyc(2);
    `CHK("read clears", 18'h00000, ist)
    `CHK("int out", 1'b0, ioe)
    $display("test int done");
  endtask
  task automatic t_pulse();
    @(posedge ref_clk_i) pend <= 1'b1;
    cyc(3);
    `CHK("pending int", 1'b1, ioe)
    @(posedge ref_clk_i) pcfg <= 1'b1;
    @(posedge ref_clk_i) clr <= 1'b1;
    @(posedge ref_clk_i) clr <= 1'b0;
    cyc(2);
    `CHK("int gap", 1'b0, ioe)
    cyc(DEB + 4);
    `CHK("int back", 1'b1, ioe)
    @(posedge ref_clk_i) pcfg <= 1'b0;
    @(posedge ref_clk_i) clr <= 1'b1;
    @(posedge ref_clk_i) clr <= 1'b0;
    cyc(2);
    `CHK("int held", 1'b1, ioe)
    @(posedge ref_clk_i) pend <= 1'b0;
    $display("test pulse done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    fails = 0;
    checked = 0;
    {rst_b_i, stall, lock, gcfg, pcfg, clr, rd, pend} = '0;
    {ext, mode, dir, dout, pdis, ien, lvl, em} = '0;
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    wait_on(1, 1'b1);
    `CHK("reset enable", 18'h00000, oe)
    t_out();
    t_rst();
    t_events();
    t_lock();
    t_int();
    t_pulse();
    tally_and_finish();
  end
endmodule // tb_keypad_expander_gpio_block
`default_nettype wire
